// file: src/sop_array.sv
// top: programmable AND / fixed OR array with registered and tristate outputs
`default_nettype none
module sop_array
	import sop_array_pkg::*;
(
	// clock and reset
	input  wire logic                          CLOCK,
	input  wire logic                          RST_N,
	// variant and fuse map, held steady by programming
	input  wire sop_array_pkg::variant_t       VARIANT,
	input  wire logic [sop_array_pkg::FUSE_BITS-1:0] FUSE_MAP,
	input  wire logic                          SECURE,
	// board pins
	input  wire logic [sop_array_pkg::NUM_DED-1:0]   DED_IN,
	input  wire logic                          OE_N,
	input  wire logic [sop_array_pkg::NUM_OUT-1:0]   PIN_IN,
	output logic [sop_array_pkg::NUM_OUT-1:0]        PIN_OUT,
	output logic [sop_array_pkg::NUM_OUT-1:0]        PIN_OE,
	// test preload
	input  wire logic                          PRELOAD,
	// fuse readback
	input  wire logic [sop_array_pkg::ADDR_W-1:0]    READ_TERM,
	output logic [sop_array_pkg::NUM_LINES-1:0]      READ_DATA,
	// power-up done
	output logic                               READY
);
	import sop_array_pkg::*;

	logic [NUM_OUT-1:0]   state;
	wire logic                 is_comb;
	wire logic                 is_all_reg;
	wire logic                 is_six_two;
	wire logic                 is_four_four;
	wire logic [NUM_DED-NUM_DED_REG-1:0] ded_high;
	wire logic [NUM_DED_REG-1:0] ded_low;
	wire logic [NUM_OUT-1:0]   fb_src;
	wire logic [NUM_OUT-1:0]   extra_col;
	wire logic [NUM_OUT-1:0]   fb_col;
	wire logic [NUM_OUT-1:0]   load_val;
	wire logic [NUM_OUT-1:0]   reg_pin;
	wire logic [NUM_OUT-1:0]   comb_pin;
	wire logic [NUM_OUT-1:0]   reg_oe;
	wire logic [NUM_OUT-1:0]   comb_oe;
	wire logic [NUM_OUT-1:0]   sum_reg;
	wire logic [NUM_OUT-1:0]   sum_comb;
	wire logic [NUM_LINES-1:0] rows [NUM_TERMS];
	wire logic [NUM_LINES-1:0] sel_row;
	wire logic                 pwr_done;
	wire logic [PWRUP_W-1:0]   next_pwr_cnt;
	wire logic                 next_ready;
	logic [PWRUP_W-1:0]   pwr_cnt;

	wire logic [NUM_OUT-1:0]   reg_mask;
	wire logic [NUM_OUT-1:0]   fb_mask;
	wire logic [NUM_COLS-1:0]  cols;
	wire logic [NUM_LINES-1:0] lines;
	wire logic [NUM_TERMS-1:0] terms;
	wire logic [NUM_OUT-1:0]   sum_val;
	wire logic [NUM_OUT-1:0]   en_term;
	wire logic [NUM_OUT-1:0]   pin_fb;
	wire logic [NUM_OUT-1:0]   next_state;
	wire logic [NUM_OUT-1:0]   next_out;
	wire logic [NUM_OUT-1:0]   next_oe;
	wire logic [NUM_LINES-1:0] next_read;
	wire logic                 can_preload;
	wire logic [NUM_DED-1:0]   ded_used;

	// variant decode
	assign is_comb      = (VARIANT == ALL_COMB);
	assign is_all_reg   = (VARIANT == ALL_REG);
	assign is_six_two   = (VARIANT == REG_6_2);
	assign is_four_four = (VARIANT == REG_4_4);

	assign ded_low  = DED_IN[NUM_DED_REG-1:0];
	// fourteen inputs
	// the top two pins exist only in the all-combinatorial mix; holding
	// them low elsewhere keeps stray board levels out of the array
	assign ded_high = is_comb ? DED_IN[NUM_DED-1:NUM_DED_REG] : 2'b00;
	assign ded_used = {ded_high, ded_low};

	assign reg_mask = is_all_reg ? REG_MASK_ALL
		: is_six_two ? REG_MASK_6_2
		: is_four_four ? REG_MASK_4_4
		: REG_MASK_COMB;

	assign fb_mask = is_comb ? ~NOFB_MASK_COMB : REG_MASK_ALL;

	// registered columns see state, combinatorial ones see the pin
	// pin as input
	genvar f;
	generate
		for (f = 0; f < NUM_OUT; f++) begin : g_fb
			assign fb_src[f] = reg_mask[f] ? state[f] : PIN_IN[f];
			assign pin_fb[f] = fb_mask[f] & fb_src[f];
		end
	endgenerate

	// the two extra inputs of the all-combinatorial mix use the columns
	// that outputs 0 and 7 leave free, so the array stays 20 columns wide
	assign extra_col = NOFB_MASK_COMB
		& {ded_used[NUM_DED-1], 6'h00, ded_used[NUM_DED_REG]};
	assign fb_col = pin_fb | extra_col;
	assign cols   = {fb_col, ded_used[NUM_DED_REG-1:0]};

	genvar c;
	generate
		for (c = 0; c < NUM_COLS; c++) begin : g_col
			wire logic true_line;
			wire logic comp_line;
			assign true_line    = cols[c];
			assign comp_line    = ~cols[c];
			assign lines[2*c]   = true_line;
			assign lines[2*c+1] = comp_line;
		end
	endgenerate

	genvar t;
	generate
		for (t = 0; t < NUM_TERMS; t++) begin : g_term
			sop_product_term #(.N(NUM_LINES)) u_term (
				.lines (lines),
				.keep  (FUSE_MAP[t*NUM_LINES +: NUM_LINES]),
				.term  (terms[t])
			);
		end
	endgenerate

	// enable term
	// comb outputs use term 0 as enable and terms 1..7 as the sum
	genvar o;
	generate
		for (o = 0; o < NUM_OUT; o++) begin : g_or
			wire logic [TERMS_PER_OUT-1:0] grp;
			assign grp        = terms[o*TERMS_PER_OUT +: TERMS_PER_OUT];
			assign en_term[o] = grp[0];
			// a registered output sums all eight terms; a combinatorial
			// one gives its first term to the enable and sums the rest
			assign sum_reg[o]  = |grp;
			assign sum_comb[o] =
				|grp[TERMS_PER_OUT-1:TERMS_PER_OUT-TERMS_COMB];
			assign sum_val[o]  = reg_mask[o] ? sum_reg[o] : sum_comb[o];
		end
	endgenerate

	assign can_preload = PRELOAD && !is_comb;

	// per-output register and pin driver
	// flops of combinatorial positions simply hold; nothing reads them there
	genvar p;
	generate
		for (p = 0; p < NUM_OUT; p++) begin : g_pin
			assign load_val[p] = can_preload ? PIN_IN[p] : sum_val[p];
			assign next_state[p] = reg_mask[p] ? load_val[p] : state[p];
			assign reg_pin[p]  = ~next_state[p];
			assign comb_pin[p] = ~sum_val[p];
			assign next_out[p] = reg_mask[p] ? reg_pin[p] : comb_pin[p];
			assign reg_oe[p]   = ~OE_N;
			assign comb_oe[p]  = en_term[p];
			assign next_oe[p]  = reg_mask[p] ? reg_oe[p] : comb_oe[p];
		end
	endgenerate

	// fuse rows by term, so readback is one indexed select
	genvar r;
	generate
		for (r = 0; r < NUM_TERMS; r++) begin : g_row
			assign rows[r] = FUSE_MAP[r*NUM_LINES +: NUM_LINES];
		end
	endgenerate
	assign sel_row = rows[READ_TERM];

	// secured readback
	// a secured part shows every fuse intact, never the real pattern
	assign next_read = SECURE ? {NUM_LINES{1'b1}} : sel_row;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state <= REG_RESET;
		end else begin
			state <= next_state;
		end
	end

	// outputs are registered, so pins follow the array one clock late
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			PIN_OUT <= ~REG_RESET;
		end else begin
			PIN_OUT <= next_out;
		end
	end

	// drivers stay off through reset so the board owns the pins
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			PIN_OE <= '0;
		end else begin
			PIN_OE <= next_oe;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			READ_DATA <= '0;
		end else begin
			READ_DATA <= next_read;
		end
	end

	// power-up window
	// the counter saturates, so READY never drops once the window is over
	assign pwr_done     = (pwr_cnt == PWRUP_W'(PWRUP_CYC));
	assign next_pwr_cnt = pwr_done ? pwr_cnt : pwr_cnt + PWRUP_W'(1);
	assign next_ready   = pwr_done;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pwr_cnt <= '0;
		end else begin
			pwr_cnt <= next_pwr_cnt;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			READY <= 1'b0;
		end else begin
			READY <= next_ready;
		end
	end
endmodule // sop_array
`default_nettype wire

// file: src/sop_array_pkg.sv
// constants, variant codes and fuse-map layout of the sum-of-products array
`default_nettype none
package sop_array_pkg;
	// array geometry
	localparam int NUM_OUT       = 8;
	localparam int NUM_DED       = 14;
	localparam int NUM_DED_REG   = 12;
	localparam int NUM_COLS      = 20;
	localparam int NUM_LINES     = 2 * NUM_COLS;
	localparam int TERMS_PER_OUT = 8;
	localparam int TERMS_COMB    = 7;
	localparam int NUM_TERMS     = NUM_OUT * TERMS_PER_OUT;
	localparam int FUSE_BITS     = NUM_TERMS * NUM_LINES;
	localparam int ADDR_W        = 6;

	// variants
	typedef enum logic [1:0] {
		ALL_COMB = 2'b00,
		ALL_REG  = 2'b01,
		REG_6_2  = 2'b10,
		REG_4_4  = 2'b11
	} variant_t;

	// registered-output masks per variant; outputs 1..6 of 6+2, 2..5 of 4+4
	localparam logic [NUM_OUT-1:0] REG_MASK_COMB = 8'h00;
	localparam logic [NUM_OUT-1:0] REG_MASK_ALL  = 8'hff;
	localparam logic [NUM_OUT-1:0] REG_MASK_6_2  = 8'h7e;
	localparam logic [NUM_OUT-1:0] REG_MASK_4_4  = 8'h3c;
	// outputs without feedback in the combinatorial variant (ends)
	localparam logic [NUM_OUT-1:0] NOFB_MASK_COMB = 8'h81;

	// power-up reset
	localparam logic [NUM_OUT-1:0] REG_RESET   = 8'h00;
	localparam int CLOCK_MHZ    = 10;
	localparam int PWRUP_MAX_NS = 1000;
	localparam int PWRUP_CYC    = (PWRUP_MAX_NS * CLOCK_MHZ) / 1000;
	localparam int PWRUP_W      = 8;
endpackage : sop_array_pkg
`default_nettype wire

// file: src/sop_product_term.sv
// one programmable product term over true and complement lines
`default_nettype none
module sop_product_term #(
	parameter int N = 40
) (
	input  wire logic [N-1:0] lines,
	input  wire logic [N-1:0] keep,
	output logic              term
);
	assign term = &(lines | ~keep);
endmodule // sop_product_term
`default_nettype wire

// file: tb/sop_board.sv
// board side: drives the pins whenever the array floats them
`default_nettype none
module sop_board (
	// array side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// tester side
	input  wire logic [7:0] drive_val,
	output logic [7:0]      pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive_val);
endmodule // sop_board
`default_nettype wire

// file: tb/sop_array_asserts.sv
// pin-level checks of the array
`default_nettype none
module sop_array_asserts
	import sop_array_pkg::*;
(
	input wire logic                 CLOCK,
	input wire logic                 RST_N,
	input wire variant_t             VARIANT,
	input wire logic [FUSE_BITS-1:0] FUSE_MAP,
	input wire logic                 SECURE,
	input wire logic                 OE_N,
	input wire logic [NUM_OUT-1:0]   PIN_IN,
	input wire logic [NUM_OUT-1:0]   PIN_OUT,
	input wire logic [NUM_OUT-1:0]   PIN_OE,
	input wire logic                 PRELOAD,
	input wire logic [ADDR_W-1:0]    READ_TERM,
	input wire logic [NUM_LINES-1:0] READ_DATA,
	input wire logic                 READY
);
	timeunit 1ns;
	timeprecision 1ns;
	// first edge after release still carries reset values
	logic run;
	always_ff @(posedge CLOCK) run <= RST_N;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N || !run);
	reset_pins_a: assert property (disable iff (1'b0)
		!RST_N |=> PIN_OUT == 8'hff && PIN_OE == 8'h00) else $error("reset pins");
	ready_time_a: assert property (disable iff (1'b0)
		$rose(RST_N) |-> ##[8:11] $rose(READY)) else $error("ready late");
	ready_hold_a: assert property (READY |=> READY) else $error("ready lost");
	oe_pin_a: assert property (VARIANT == ALL_REG |=>
		PIN_OE == {8{!$past(OE_N)}}) else $error("enable pin");
	preload_a: assert property (VARIANT == ALL_REG && PRELOAD |=>
		PIN_OUT == ~$past(PIN_IN)) else $error("preload");
	open_term_a: assert property (VARIANT == ALL_REG && !PRELOAD &&
		FUSE_MAP == '0 |=> PIN_OUT == 8'h00) else $error("open term");
	both_forms_a: assert property (VARIANT == ALL_REG && !PRELOAD &&
		FUSE_MAP == {64{40'h3}} |=> PIN_OUT == 8'hff) else $error("both forms");
	secure_read_a: assert property (SECURE |=> READ_DATA == '1)
		else $error("secure read");
	plain_read_a: assert property (!SECURE |=> READ_DATA ==
		40'($past(FUSE_MAP) >> 40 * $past(READ_TERM))) else $error("readback");
	cover property (PRELOAD && OE_N);
	cover property (SECURE);
	cover property ($rose(READY));
endmodule // sop_array_asserts
bind sop_array sop_array_asserts i_sop_array_asserts (.*);
`default_nettype wire

// file: tb/sop_array_tb.sv
// self-checking bench for the sum-of-products array
`default_nettype none
module sop_array_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sop_array_pkg::*;
	typedef struct {logic [7:0] o, e; logic [39:0] r;} note_t;
	note_t q[$], n, nt;
	logic clock = 0, rst_n = 0, oe_n = 1, pre = 0, sec = 0, o1, p1, s1;
	logic [13:0] ded = 0, d;
	logic [7:0] drive = 0, dv, pin_out, pin_oe, pin_in, msk, en;
	variant_t variant = ALL_REG;
	logic [5:0] term = 0, tm;
	logic [FUSE_BITS-1:0] fuse = '0;
	logic [39:0] rd;
	logic ready;
	int fail_count, comparisons, cycles, seed = 32'h062b86a5;
	always #50 clock = ~clock;
	sop_array i_sop_array (.CLOCK(clock), .RST_N(rst_n), .VARIANT(variant),
		.FUSE_MAP(fuse), .SECURE(sec), .DED_IN(ded), .OE_N(oe_n),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PRELOAD(pre), .READ_TERM(term), .READ_DATA(rd), .READY(ready));
	sop_board i_sop_board (.pin_out(pin_out), .pin_oe(pin_oe),
		.drive_val(drive), .pin_level(pin_in));
	task automatic check(string what, logic [39:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// mode 0 all open, 1 true and complement, 2 one input per output
	function automatic logic [FUSE_BITS-1:0] build(int m);
		logic [39:0] t;
		build = '0;
		for (int i = 0; i < 64; i++) begin
			t = (m == 0) ? 40'h0 : 40'h3;
			if (m == 2 && i % 8 == 0)
				t = 40'h1 << (i / 4 + i / 8 % 2);
			build[i*40 +: 40] = t;
		end
	endfunction
	always @(negedge clock)
		if (q.size() > 0) begin
			n = q.pop_front();
			check("out", 40'(pin_out), 40'(n.o));
			check("oe", 40'(pin_oe), 40'(n.e));
			check("read", rd, n.r);
		end
	always @(posedge clock)
		if (++cycles == 2000) begin
			fail_count++;
			test_done;
		end
	initial begin
		repeat (20) @(posedge clock);
		q.push_back('{8'hff, 8'h00, 40'h0});
		@(posedge clock) rst_n <= 1;
		repeat (12) @(posedge clock);
		for (int v = 0; v < 4; v++) begin
			for (int m = 0; m < 3; m++) begin
				variant <= variant_t'(v);
				fuse <= build(m);
				msk = v == 0 ? REG_MASK_COMB : v == 1 ? REG_MASK_ALL
					: v == 2 ? REG_MASK_6_2 : REG_MASK_4_4;
				for (int i = 0; i < 30; i++) begin
					@(posedge clock);
					{d, dv, tm, o1, p1, s1} = 31'($random(seed));
					// preload only while the pins float
					p1 &= o1;
					en = m == 0 ? 8'hff : m == 1 ? 8'h00 : d[7:0] ^ 8'haa;
					nt.o = p1 && v != 0 ? ~dv : m == 0 ? 8'h00
						: m == 1 ? 8'hff : ~(d[7:0] ^ 8'haa);
					// combinatorial pins show the inverted sum of terms 1..7
					nt.o = (msk & nt.o) | (~msk & (m == 0 ? 8'h00 : 8'hff));
					nt.e = (msk & {8{~o1}}) | (~msk & en);
					nt.r = s1 ? '1 : fuse[tm*40 +: 40];
					{ded, drive, term, oe_n, pre, sec} <=
						{d, dv, tm, o1, p1, s1};
					repeat (2) @(posedge clock);
					q.push_back(nt);
				end
			end
		end
		repeat (2) @(posedge clock);
		test_done;
	end
endmodule // sop_array_tb
`default_nettype wire
